/* logic/drf_pkg.sv */
/*
  shared constants of the digital retransmission formatter: register map,
  field positions, reset values, format and source codes, limits.
  assumes a 32-bit axi4-lite register bus and byte addressing.
*/
`default_nettype none
package drf_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SCALE_BOTTOM = 8'h04;
  localparam logic [7:0] ADDR_SCALE_TOP = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_FMT_LSB = 4;
  localparam int CTRL_POL_BIT = 8;
  localparam int CTRL_DROP_LSB = 12;
  localparam int STATUS_SAT_BIT = 16;
  localparam logic [2:0] CTRL_SRC_RESET = 3'h0;
  localparam logic [1:0] CTRL_FMT_RESET = 2'h0;
  localparam logic CTRL_POL_RESET = 1'b1;
  localparam logic [1:0] CTRL_DROP_RESET = 2'h0;
  localparam logic [31:0] SCALE_BOTTOM_RESET = 32'h0000_0000;
  localparam logic [31:0] SCALE_TOP_RESET = 32'h0000_FFFF;
  // ----------------------------------------------------------------
  // format and source codes
  // ----------------------------------------------------------------
  localparam logic [1:0] FMT_SIGNED = 2'h0;
  localparam logic [1:0] FMT_UNSIGNED = 2'h1;
  localparam logic [1:0] FMT_SCALED = 2'h2;
  localparam logic [1:0] FMT_BCD = 2'h3;
  localparam logic [2:0] SRC_CH1 = 3'h0;
  localparam logic [2:0] SRC_CH2 = 3'h1;
  localparam logic [2:0] SRC_TEMP1 = 3'h2;
  localparam logic [2:0] SRC_TEMP2 = 3'h3;
  localparam logic [2:0] SRC_REJECT = 3'h4;
  // ----------------------------------------------------------------
  // limits and timing
  // ----------------------------------------------------------------
  localparam logic signed [31:0] SIGNED_HI = 32'sh0000_7FFF;
  localparam logic signed [31:0] SIGNED_LO = -32'sh0000_7FFF;
  localparam logic signed [31:0] UNSIGNED_HI = 32'sh0000_FFFF;
  localparam logic [15:0] SCALE_FULL = 16'hFFFF;
  localparam logic [31:0] BCD_MAX = 32'h0000_270F;
  localparam logic [5:0] DIV_STEPS = 6'h30;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : drf_pkg
`default_nettype wire

/* logic/drf_fmt_if.sv */
/*
  carrier between the register front end and the formatting core.
  assumes both ends share aclk.
*/
`timescale 1ns/10ps
`default_nettype none
interface drf_fmt_if;
  logic [31:0] value;
  logic [1:0] fmt;
  logic [1:0] drop;
  logic [31:0] scale_bottom;
  logic [31:0] scale_top;
  logic [15:0] word;
  logic saturated;
  modport ctl (output value, fmt, drop, scale_bottom, scale_top,
               input word, saturated);
  modport core (input value, fmt, drop, scale_bottom, scale_top,
                output word, saturated);
endinterface : drf_fmt_if
`default_nettype wire

/* logic/drf_core.sv */
/*
  formatting core: turns the selected display value into a 16-bit word.
  assumes inputs synchronous to aclk; a new word every 2 cycles, or
  DIV_STEPS + 2 cycles in scaled binary.
*/
`timescale 1ns/10ps
`default_nettype none
module drf_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  drf_fmt_if.core bus
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_DIV = 2'b01, S_DONE = 2'b11
  } drf_state_e;

  drf_state_e st, next_st;
  logic [5:0] cnt, next_cnt;
  logic [47:0] quo, next_quo;
  logic [32:0] rem, next_rem;
  logic signed [31:0] cap_val, next_cap_val;
  logic [1:0] cap_fmt, next_cap_fmt;
  logic [1:0] cap_drop, next_cap_drop;
  logic [31:0] cap_top, next_cap_top;
  logic [15:0] word, next_word;
  logic sat, next_sat;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] drop_digits(input logic [31:0] v,
                                              input logic [1:0] d);
    case (d)
      2'h0: drop_digits = v;
      2'h1: drop_digits = v / 32'h0000_000A;
      2'h2: drop_digits = v / 32'h0000_0064;
      default: drop_digits = v / 32'h0000_03E8;
    endcase
  endfunction : drop_digits

  function automatic logic [15:0] to_bcd(input logic [13:0] v);
    logic [29:0] sh;
    sh = {16'h0000, v};
    for (int i = 0; i < 14; i++) begin
      for (int n = 0; n < 4; n++) begin
        if (sh[14 + 4*n +: 4] > 4'h4) begin
          sh[14 + 4*n +: 4] = sh[14 + 4*n +: 4] + 4'h3;
        end
      end
      sh = {sh[28:0], 1'b0};
    end
    to_bcd = sh[29:14];
  endfunction : to_bcd

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic signed [32:0] diff;
  logic [32:0] rem_sh;
  logic [31:0] kept;
  assign diff = $signed({bus.value[31], bus.value})
              - $signed({bus.scale_bottom[31], bus.scale_bottom});
  assign rem_sh = {rem[31:0], quo[47]};
  assign kept = drop_digits(cap_val, cap_drop);

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_quo = quo;
    next_rem = rem;
    next_cap_val = cap_val;
    next_cap_fmt = cap_fmt;
    next_cap_drop = cap_drop;
    next_cap_top = cap_top;
    next_word = word;
    next_sat = sat;
    case (st)
      S_IDLE: begin
        next_cap_val = bus.value;
        next_cap_fmt = bus.fmt;
        next_cap_drop = bus.drop;
        next_cap_top = bus.scale_top;
        next_rem = 33'h0_0000_0000;
        next_cnt = 6'h00;
        next_st = S_DONE;
        if (bus.fmt == drf_pkg::FMT_SCALED) begin
          // value at or below bottom gives zero; zero or negative top cannot be divided, pin to full scale
          if (diff <= 0) begin
            next_quo = 48'h0000_0000_0000;
          end else if (bus.scale_top[31] || bus.scale_top == 32'h0) begin
            next_quo = 48'hFFFF_FFFF_FFFF;
          end else begin
            next_quo = 48'(diff[31:0]) * 48'(drf_pkg::SCALE_FULL);
            next_st = S_DIV;
          end
        end
      end
      S_DIV: begin
        // restoring division, one quotient bit a cycle: trades speed
        // for no wide divider on the path
        if (rem_sh >= {1'b0, cap_top}) begin
          next_rem = rem_sh - {1'b0, cap_top};
          next_quo = {quo[46:0], 1'b1};
        end else begin
          next_rem = rem_sh;
          next_quo = {quo[46:0], 1'b0};
        end
        next_cnt = cnt + 6'h01;
        if (cnt == drf_pkg::DIV_STEPS - 6'h01) begin
          next_st = S_DONE;
        end
      end
      S_DONE: begin
        next_st = S_IDLE;
        next_sat = 1'b0;
        case (cap_fmt)
          drf_pkg::FMT_SIGNED: begin
            if (cap_val > drf_pkg::SIGNED_HI) begin
              next_word = drf_pkg::SIGNED_HI[15:0];
              next_sat = 1'b1;
            end else if (cap_val < drf_pkg::SIGNED_LO) begin
              next_word = drf_pkg::SIGNED_LO[15:0];
              next_sat = 1'b1;
            end else begin
              next_word = cap_val[15:0];
            end
          end
          drf_pkg::FMT_UNSIGNED: begin
            if (cap_val < 0) begin
              next_word = 16'h0000;
              next_sat = 1'b1;
            end else if (cap_val > drf_pkg::UNSIGNED_HI) begin
              next_word = drf_pkg::UNSIGNED_HI[15:0];
              next_sat = 1'b1;
            end else begin
              next_word = cap_val[15:0];
            end
          end
          drf_pkg::FMT_SCALED: begin
            if (quo > 48'(drf_pkg::SCALE_FULL)) begin
              next_word = drf_pkg::SCALE_FULL;
              next_sat = 1'b1;
            end else begin
              next_word = quo[15:0];
            end
          end
          default: begin
            if (cap_val < 0) begin
              next_word = 16'h0000;
              next_sat = 1'b1;
            end else if (kept > drf_pkg::BCD_MAX) begin
              next_word = to_bcd(drf_pkg::BCD_MAX[13:0]);
              next_sat = 1'b1;
            end else begin
              next_word = to_bcd(kept[13:0]);
            end
          end
        endcase
      end
      default: next_st = S_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= S_IDLE;
      cnt <= 6'h00;
      quo <= 48'h0000_0000_0000;
      rem <= 33'h0_0000_0000;
      cap_val <= 32'sh0000_0000;
      cap_fmt <= drf_pkg::CTRL_FMT_RESET;
      cap_drop <= drf_pkg::CTRL_DROP_RESET;
      cap_top <= drf_pkg::SCALE_TOP_RESET;
      word <= 16'h0000;
      sat <= 1'b0;
    end else if (ce) begin
      st <= next_st;
      cnt <= next_cnt;
      quo <= next_quo;
      rem <= next_rem;
      cap_val <= next_cap_val;
      cap_fmt <= next_cap_fmt;
      cap_drop <= next_cap_drop;
      cap_top <= next_cap_top;
      word <= next_word;
      sat <= next_sat;
    end
  end

  assign bus.word = word;
  assign bus.saturated = sat;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_done_in(logic [1:0] f);
    st == S_DONE && ce && cap_fmt == f;
  endsequence

  property p_signed_range;
    s_done_in(drf_pkg::FMT_SIGNED) |=>
      ($signed(word) <= 16'sh7FFF && $signed(word) >= -16'sh7FFF);
  endproperty
  a_signed_range: assert property (p_signed_range)
    else $error("signed word outside -32767..32767");

  property p_unsigned_neg;
    s_done_in(drf_pkg::FMT_UNSIGNED) ##0 cap_val < 0 |=> word == 16'h0000;
  endproperty
  a_unsigned_neg: assert property (p_unsigned_neg)
    else $error("negative value did not give zero in unsigned format");

  property p_bcd_digits;
    s_done_in(drf_pkg::FMT_BCD) |=> word[3:0] <= 4'h9 && word[7:4] <= 4'h9
      && word[11:8] <= 4'h9 && word[15:12] <= 4'h9;
  endproperty
  a_bcd_digits: assert property (p_bcd_digits)
    else $error("bcd nibble above nine");

  property p_bcd_drop;
    s_done_in(drf_pkg::FMT_BCD) ##0 cap_val == 32'sh0000_04D2 |=>
      word == (($past(cap_drop) == 2'h0) ? 16'h1234 :
               ($past(cap_drop) == 2'h1) ? 16'h0123 :
               ($past(cap_drop) == 2'h2) ? 16'h0012 : 16'h0001);
  endproperty
  a_bcd_drop: assert property (p_bcd_drop)
    else $error("digit drop gave wrong bcd word for 1234");

  // bound assumes ce stays high through the divide
  property p_scaled_example;
    st == S_IDLE && ce && bus.fmt == drf_pkg::FMT_SCALED
      && bus.value == 32'h0000_0014 && bus.scale_bottom == 32'h0
      && bus.scale_top == 32'h0000_7FFF |->
      ##[1:60] (st == S_IDLE && word == 16'h0028);
  endproperty
  a_scaled_example: assert property (p_scaled_example)
    else $error("scaled 20 over 32767 did not give 40");

  property p_signed_sat;
    s_done_in(drf_pkg::FMT_SIGNED) ##0 cap_val > drf_pkg::SIGNED_HI |=>
      word == 16'h7FFF && sat;
  endproperty
  a_signed_sat: assert property (p_signed_sat)
    else $error("signed overflow wrapped instead of saturating");
endmodule : drf_core
`default_nettype wire

/* logic/drf_top.sv */
/*
  digital retransmission formatter: axi4-lite register slave, value
  source select, output polarity and the parallel 16-bit output word.
  assumes one clock aclk, synchronous active-low reset, inputs already
  synchronous to aclk, and a master that keeps axi4-lite handshakes.
*/
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - signed binary format drives the value as signed word, -32767..32767.
// - unsigned binary format drives the value as unsigned word, 0..65535.
// - bcd format retransmits at most four decimal digits.
// - after reset the format selection is signed binary.
// - active-low polarity: logic one is 0V, logic zero is high.
// - active-high polarity: logic one is high, logic zero is 0V.
// - bcd digit drop 0..3 discards that many low decimal digits.
// - scaled binary gives (value - bottom) * 65535 / top, rounding allowed.
// - the output is 16 bits wide in every format.
// - source is channel 1, channel 2, temp 1, temp 2 or rejection.
module drf_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] ch1_value,
  input wire logic [31:0] ch2_value,
  input wire logic [31:0] temp1_value,
  input wire logic [31:0] temp2_value,
  input wire logic [31:0] reject_value,
  output logic [15:0] dout
);
  drf_fmt_if fbus ();

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [2:0] src, next_src;
  logic [1:0] fmt, next_fmt;
  logic pol_high, next_pol_high;
  logic [1:0] drop, next_drop;
  logic [31:0] scale_bottom, next_scale_bottom;
  logic [31:0] scale_top, next_scale_top;
  logic aw_got, next_aw_got;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic w_got, next_w_got;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [15:0] next_dout;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[8*b +: 8] = data[8*b +: 8];
      end
    end
  endfunction : merge

  function automatic logic [7:0] word_addr(input logic [ADDR_W-1:0] a);
    logic [7:0] w;
    w = 8'(a);
    word_addr = {w[7:2], 2'b00};
  endfunction : word_addr

  logic [31:0] ctrl_word;
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[drf_pkg::CTRL_SRC_LSB +: 3] = src;
    ctrl_word[drf_pkg::CTRL_FMT_LSB +: 2] = fmt;
    ctrl_word[drf_pkg::CTRL_POL_BIT] = pol_high;
    ctrl_word[drf_pkg::CTRL_DROP_LSB +: 2] = drop;
  end

  // ----------------------------------------------------------------
  // source select and core
  // ----------------------------------------------------------------
  always_comb begin
    case (src)
      drf_pkg::SRC_CH2: fbus.value = ch2_value;
      drf_pkg::SRC_TEMP1: fbus.value = temp1_value;
      drf_pkg::SRC_TEMP2: fbus.value = temp2_value;
      drf_pkg::SRC_REJECT: fbus.value = reject_value;
      default: fbus.value = ch1_value;
    endcase
  end
  assign fbus.fmt = fmt;
  assign fbus.drop = drop;
  assign fbus.scale_bottom = scale_bottom;
  assign fbus.scale_top = scale_top;

  drf_core u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .bus(fbus.core)
  );

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  // readies are gated by ce so nothing is taken while state is frozen
  assign s_axi_awready = ce && !aw_got && !bvalid;
  assign s_axi_wready = ce && !w_got && !bvalid;
  assign s_axi_arready = ce && !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  logic aw_take, w_take, wr_fire;
  logic [7:0] wa, ra;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [31:0] cw;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = (aw_got || aw_take) && (w_got || w_take);
  assign wa = word_addr(aw_got ? aw_addr : s_axi_awaddr);
  assign wd = w_got ? w_data : s_axi_wdata;
  assign ws = w_got ? w_strb : s_axi_wstrb;
  assign ra = word_addr(s_axi_araddr);
  assign cw = merge(ctrl_word, wd, ws);

  always_comb begin
    next_src = src;
    next_fmt = fmt;
    next_pol_high = pol_high;
    next_drop = drop;
    next_scale_bottom = scale_bottom;
    next_scale_top = scale_top;
    next_aw_got = aw_got;
    next_aw_addr = aw_addr;
    next_w_got = w_got;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (aw_take) begin
      next_aw_got = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      next_w_got = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = drf_pkg::AXI_OKAY;
      case (wa)
        drf_pkg::ADDR_CTRL: begin
          next_src = cw[drf_pkg::CTRL_SRC_LSB +: 3];
          next_fmt = cw[drf_pkg::CTRL_FMT_LSB +: 2];
          next_pol_high = cw[drf_pkg::CTRL_POL_BIT];
          next_drop = cw[drf_pkg::CTRL_DROP_LSB +: 2];
        end
        drf_pkg::ADDR_SCALE_BOTTOM: begin
          next_scale_bottom = merge(scale_bottom, wd, ws);
        end
        drf_pkg::ADDR_SCALE_TOP: next_scale_top = merge(scale_top, wd, ws);
        drf_pkg::ADDR_STATUS: next_bresp = drf_pkg::AXI_OKAY;
        default: next_bresp = drf_pkg::AXI_SLVERR;
      endcase
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = drf_pkg::AXI_OKAY;
      case (ra)
        drf_pkg::ADDR_CTRL: next_rdata = ctrl_word;
        drf_pkg::ADDR_SCALE_BOTTOM: next_rdata = scale_bottom;
        drf_pkg::ADDR_SCALE_TOP: next_rdata = scale_top;
        drf_pkg::ADDR_STATUS: begin
          next_rdata = {15'h0000, fbus.saturated, fbus.word};
        end
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = drf_pkg::AXI_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  always_comb begin
    if (pol_high) begin
      next_dout = fbus.word;
    end else begin
      next_dout = ~fbus.word;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src <= drf_pkg::CTRL_SRC_RESET;
      fmt <= drf_pkg::CTRL_FMT_RESET;
      pol_high <= drf_pkg::CTRL_POL_RESET;
      drop <= drf_pkg::CTRL_DROP_RESET;
      scale_bottom <= drf_pkg::SCALE_BOTTOM_RESET;
      scale_top <= drf_pkg::SCALE_TOP_RESET;
      aw_got <= 1'b0;
      aw_addr <= '0;
      w_got <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= drf_pkg::AXI_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= drf_pkg::AXI_OKAY;
      dout <= 16'h0000;
    end else if (ce) begin
      src <= next_src;
      fmt <= next_fmt;
      pol_high <= next_pol_high;
      drop <= next_drop;
      scale_bottom <= next_scale_bottom;
      scale_top <= next_scale_top;
      aw_got <= next_aw_got;
      aw_addr <= next_aw_addr;
      w_got <= next_w_got;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      dout <= next_dout;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reset_format;
    !$past(aresetn) |-> fmt == drf_pkg::FMT_SIGNED && !bvalid && !rvalid;
  endproperty
  a_reset_format: assert property (p_reset_format)
    else $error("format not signed binary after reset");

  property p_active_low;
    ce && !pol_high |=> dout == ~$past(fbus.word);
  endproperty
  a_active_low: assert property (p_active_low)
    else $error("active-low output not inverted");

  property p_active_high;
    ce && pol_high |=> dout == $past(fbus.word);
  endproperty
  a_active_high: assert property (p_active_high)
    else $error("active-high output not equal to word");

  property p_source_sel;
    src == drf_pkg::SRC_REJECT |-> fbus.value == reject_value;
  endproperty
  a_source_sel: assert property (p_source_sel)
    else $error("rejection source not routed to formatter");
endmodule : drf_top
`default_nettype wire

/* dv/drf_line_reader.sv */
/*
  partner: equipment reading the 16 parallel output lines.
  assumes it is told which polarity the instrument drives.
*/
`timescale 1ns/10ps
`default_nettype none
module drf_line_reader (
  input wire logic [15:0] lines,
  input wire logic active_high,
  output logic [15:0] word
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign word = active_high ? lines : ~lines;
endmodule : drf_line_reader
`default_nettype wire

/* dv/drf_top_test.sv */
/*
  bench of drf_top: axi4-lite tasks, one task per scenario.
  assumes ce held high and the reader decodes the polarity.
*/
`timescale 1ns/10ps
`default_nettype none
module drf_top_test;
  logic aclk = 1'b0, aresetn = 1'b0, pol = 1'b1;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wr_, bv, arr, rv;
  logic [1:0] bresp, rresp, bs_v, rs_v;
  logic [31:0] wd = 32'h0, rdo, rd_v, v [5] = '{default: 32'h0};
  logic [15:0] dout, word;
  int err_total = 0, cmp_count = 0, cyc = 0;
  drf_top dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdo), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .ch1_value(v[0]), .ch2_value(v[1]),
    .temp1_value(v[2]), .temp2_value(v[3]), .reject_value(v[4]),
    .dout(dout));
  drf_line_reader rdr (.lines(dout), .active_high(pol), .word(word));
  // ----------------------------------------------------------------
  // clock, watchdog and report
  // ----------------------------------------------------------------
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // ----------------------------------------------------------------
  // bus tasks; the slave's answer time is never assumed
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_) wv <= 1'b0;
    end while (!bv);
    bs_v = bresp;
    br <= 1'b0;
    pol <= (a == 8'h00) ? d[8] : pol;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rd_v = rdo;
    rs_v = rresp;
    rr <= 1'b0;
  endtask : rd
  // a new value reaches the lines 51 to 100 edges later in scaled mode
  task automatic out_is(input string n, input logic [31:0] val,
                        input logic [15:0] e);
    v[0] <= val;
    repeat (120) @(posedge aclk);
    chk(n, {16'h0, word}, {16'h0, e});
  endtask : out_is
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(8'h00);
    chk("ctrl", rd_v, 32'h100);
    rd(8'h08);
    chk("top", rd_v, 32'hFFFF);
    rd(8'h10);
    chk("rresp", {30'h0, rs_v}, 32'h2);
    // unmapped write is refused, status write is ignored but accepted
    wr(8'h10, 32'h0);
    chk("bresp", {30'h0, bs_v}, 32'h2);
    wr(8'h0C, 32'h0);
    chk("bresp_ok", {30'h0, bs_v}, 32'h0);
    out_is("neg", 32'hFFFF_FFFB, 16'hFFFB);
    $display("reset done");
  endtask : t_reset
  task automatic t_bin();
    out_is("shi", 32'h9C40, 16'h7FFF);
    rd(8'h0C);
    chk("status", rd_v, 32'h0001_7FFF);
    out_is("slo", 32'hFFFF_63C0, 16'h8001);
    wr(8'h00, 32'h110);
    out_is("uhi", 32'h0001_1170, 16'hFFFF);
    out_is("ulo", 32'hFFFF_FFFF, 16'h0000);
    out_is("umid", 32'hABCD, 16'hABCD);
    $display("binary done");
  endtask : t_bin
  task automatic t_scaled();
    wr(8'h00, 32'h120);
    wr(8'h04, 32'h4);
    out_is("sc1", 32'h14, 16'h0010);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h7FFF);
    out_is("sc2", 32'h14, 16'h0028);
    $display("scaled done");
  endtask : t_scaled
  task automatic t_bcd();
    logic [15:0] e [4] = '{16'h1234, 16'h0123, 16'h0012, 16'h0001};
    for (int d = 0; d < 4; d++) begin
      wr(8'h00, 32'h130 | (d << 12));
      out_is("bcd", 32'h04D2, e[d]);
    end
    $display("bcd done");
  endtask : t_bcd
  task automatic t_pol_src();
    wr(8'h00, 32'h000);
    out_is("low", 32'h5, 16'h0005);
    chk("lines", {16'h0, dout}, 32'hFFFA);
    for (int s = 0; s < 5; s++) begin
      v[s] <= 32'h64 + s;
      wr(8'h00, 32'h100 | s);
      repeat (20) @(posedge aclk);
      chk("src", {16'h0, dout}, 32'h64 + s);
    end
    $display("polarity and source done");
  endtask : t_pol_src
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_bin();
    t_scaled();
    t_bcd();
    t_pol_src();
    test_done();
  end
endmodule : drf_top_test
`default_nettype wire
